/* rtl/gain_channel.sv */
// One channel of front-end automatic gain: peak tracking, clip cut-back, paced increments.
// Assumes line_end and sample_en are single-cycle strobes in the clk_sys domain.
`include "vfgc_regs.svh"

module gain_channel import vfgc_pkg::*; #(
  parameter int SAMPLE_W = 11
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // Configuration
  input wire logic agc_en,
  input wire gain_t manual_gain,
  input wire logic [3:0] ref_mask,
  input wire logic [7:0] step_speed,
  input wire logic [7:0] step_delay,
  // Converter and reference measurements
  input wire logic sample_en,
  input wire logic [SAMPLE_W-1:0] sample,
  input wire logic line_end,
  input wire logic [3:0] ref_high,
  input wire logic [3:0] ref_low,
  // Gain in use
  output gain_t gain
);

  logic [SAMPLE_W-1:0] peak;
  logic [7:0] speed_cnt;
  logic [7:0] delay_cnt;
  logic clip;
  logic cut;
  logic raise;

  // ==========================================================================
  // Peak of the line, taken only on converter strobes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      peak <= '0;
    end else if (ce) begin
      if (line_end) begin
        peak <= '0;
      end else if (sample_en && sample > peak) begin
        peak <= sample;
      end
    end
  end

  // Saturated code or any selected reference over nominal forces a cut
  assign clip = &peak;
  assign cut = clip || |(ref_high & ref_mask);
  // Raise only while every selected reference is short and headroom remains
  assign raise = (ref_mask != 4'h0) && &(ref_low | ~ref_mask) && (peak[SAMPLE_W-1 -: 2] != 2'b11);

  // ==========================================================================
  // Gain loop; manual codes pass straight through while the loop is off
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gain <= `RST_GAIN;
      speed_cnt <= 8'h00;
      delay_cnt <= 8'h00;
    end else if (ce) begin
      if (!agc_en) begin
        gain <= manual_gain;
        speed_cnt <= 8'h00;
        delay_cnt <= 8'h00;
      end else if (line_end) begin
        if (cut) begin
          gain <= (gain >= `AGC_STEP) ? gain - `AGC_STEP : 16'h0000;
          delay_cnt <= step_delay;
          speed_cnt <= 8'h00;
        end else if (delay_cnt != 8'h00) begin
          delay_cnt <= delay_cnt - 8'h01;
        end else if (raise) begin
          if (speed_cnt >= step_speed) begin
            gain <= (gain <= `AGC_MAX - `AGC_STEP) ? gain + `AGC_STEP : `AGC_MAX;
            speed_cnt <= 8'h00;
          end else begin
            speed_cnt <= speed_cnt + 8'h01;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_clip_cut: assert property (ce && agc_en && line_end && clip && gain >= `AGC_STEP
    |=> gain == $past(gain) - `AGC_STEP) else $error("clip did not cut gain");
  a_delay_hold: assert property (ce && agc_en && line_end && delay_cnt != 8'h00
    |=> gain <= $past(gain)) else $error("gain rose during delay");
  a_speed_pace: assert property (ce && agc_en && line_end && !cut && delay_cnt == 8'h00
    && speed_cnt < step_speed |=> gain == $past(gain)) else $error("gain rose too fast");
  a_peak_strobe: assert property (!(ce && (sample_en || line_end)) |=> $stable(peak))
    else $error("peak moved without strobe");
  a_mask_ignore: assert property (ce && agc_en && line_end && !clip && delay_cnt == 8'h00
    && (ref_high & ref_mask) == 4'h0 && ref_mask == 4'h0 |=> gain == $past(gain))
    else $error("unselected reference moved gain");

endmodule

/* rtl/video_frontend_gain_control.sv */
// Gain and routing control of a four-channel video front end with its host register port.
// Assumes synchronous pin inputs, external open-drain resolution of SCL and SDA,
// and reference flags from the video processor pulsed with line_end.
`include "vfgc_regs.svh"

module video_frontend_gain_control import vfgc_pkg::*; #(
  parameter int SAMPLE_W = 11,
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // Host port pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Converter samples and line timing
  input wire logic adc_sample_en,
  input wire logic [3:0][SAMPLE_W-1:0] adc_sample,
  input wire logic line_end,
  // Amplitude reference flags
  input wire logic [3:0] fe_ref_high,
  input wire logic [3:0] fe_ref_low,
  input wire logic [3:0] be_ref_high,
  input wire logic [3:0] be_ref_low,
  // Analog controls
  output logic [3:0][1:0] ch_src_sel,
  output logic [3:0] clamp_mid,
  output gain_t [3:0] ch_gain,
  output logic [7:0] be_gain,
  output logic agc_active
);

  logic scl_q;
  logic sda_q;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  i2c_state_e state;
  i2c_state_e ack_next;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] sub;
  logic reg_wr_en;
  logic [7:0] reg_wr_addr;
  logic [7:0] reg_wr_data;
  logic [7:0] rd_byte;
  logic [7:0] route_reg;
  logic [7:0] agc_ctrl;
  logic [7:0] ref_sel;
  logic [7:0] step_speed;
  logic [7:0] step_delay;
  gain_t [3:0] man_gain;
  logic agc_en;
  logic [7:0] gain_ofs;
  logic [3:0] be_mask;

  // Channels 0 and 2 carry colour difference or chroma outside composite and SCART modes
  function automatic logic mid_clamp(input logic [1:0] kind, input int ch);
    mid_clamp = (kind == SRC_COMPONENT || kind == SRC_SVIDEO) && (ch == 0 || ch == 2);
  endfunction

  // ==========================================================================
  // Host port line conditions
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign start_cond = scl_q && scl_in && sda_q && !sda_in;
  assign stop_cond = scl_q && scl_in && !sda_q && sda_in;
  assign scl_rise = !scl_q && scl_in;
  assign scl_fall = scl_q && !scl_in;

  // ==========================================================================
  // Host port sequencer; SDA only changes after SCL falls
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      ack_next <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      sub <= 8'h00;
      sda_oe <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_wr_addr <= 8'h00;
      reg_wr_data <= 8'h00;
    end else if (ce) begin
      reg_wr_en <= 1'b0;
      if (start_cond) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_SUB, ST_WRITE: begin
            if (scl_rise && bitcnt != 4'h8) begin
              shreg <= {shreg[6:0], sda_in};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shreg[7:1] == DEV_ADDR) begin
                  sda_oe <= 1'b1;
                  state <= ST_ACK;
                  ack_next <= shreg[0] ? ST_READ : ST_SUB;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_SUB) begin
                sub <= shreg;
                sda_oe <= 1'b1;
                state <= ST_ACK;
                ack_next <= ST_WRITE;
              end else begin
                reg_wr_en <= 1'b1;
                reg_wr_addr <= sub;
                reg_wr_data <= shreg;
                sub <= sub + 8'h01;
                sda_oe <= 1'b1;
                state <= ST_ACK;
                ack_next <= ST_WRITE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              state <= ack_next;
              if (ack_next == ST_READ) begin
                tx <= rd_byte;
                sda_oe <= !rd_byte[7];
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                sda_oe <= 1'b0;
                state <= ST_RACK;
              end else begin
                sda_oe <= !tx[6];
                tx <= {tx[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_in) begin
                state <= ST_IDLE;
              end else begin
                sub <= sub + 8'h01;
              end
            end else if (scl_fall) begin
              tx <= rd_byte;
              sda_oe <= !rd_byte[7];
              bitcnt <= 4'h0;
              state <= ST_READ;
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Open-drain pins only ever pull low; clock is never stretched
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
    end
  end

  // ==========================================================================
  // Register file writes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      route_reg <= `RST_ROUTE;
      agc_ctrl <= `RST_AGC_CTRL;
      ref_sel <= `RST_REF_SEL;
      step_speed <= `RST_STEP_SPEED;
      step_delay <= `RST_STEP_DELAY;
      man_gain <= {4{`RST_GAIN}};
    end else if (ce && reg_wr_en) begin
      if (reg_wr_addr == `OFS_ROUTE) begin
        route_reg <= reg_wr_data;
      end else if (reg_wr_addr == `OFS_AGC_CTRL) begin
        agc_ctrl <= reg_wr_data;
      end else if (reg_wr_addr == `OFS_REF_SEL) begin
        ref_sel <= reg_wr_data;
      end else if (reg_wr_addr == `OFS_STEP_SPEED) begin
        step_speed <= reg_wr_data;
      end else if (reg_wr_addr == `OFS_STEP_DELAY) begin
        step_delay <= reg_wr_data;
      end else if (reg_wr_addr >= `OFS_GAIN_BASE && reg_wr_addr <= `OFS_GAIN_LAST) begin
        if (gain_ofs[0]) begin
          man_gain[gain_ofs[2:1]][15:8] <= reg_wr_data;
        end else begin
          man_gain[gain_ofs[2:1]][7:0] <= reg_wr_data;
        end
      end
    end
  end

  assign gain_ofs = (reg_wr_en ? reg_wr_addr : sub) - `OFS_GAIN_BASE;
  assign agc_en = agc_ctrl[`AGC_EN_BIT];
  assign be_mask = ref_sel[`REF_BE_LSB +: 4];

  // ==========================================================================
  // Read data; readback slots show the gain that the channels really use
  always_comb begin
    rd_byte = 8'h00;
    if (sub == `OFS_ROUTE) begin
      rd_byte = route_reg;
    end else if (sub == `OFS_AGC_CTRL) begin
      rd_byte = agc_ctrl;
    end else if (sub == `OFS_REF_SEL) begin
      rd_byte = ref_sel;
    end else if (sub == `OFS_STEP_SPEED) begin
      rd_byte = step_speed;
    end else if (sub == `OFS_STEP_DELAY) begin
      rd_byte = step_delay;
    end else if (sub == `OFS_BE_GAIN) begin
      rd_byte = be_gain;
    end else if (sub >= `OFS_GAIN_BASE && sub <= `OFS_GAIN_LAST) begin
      rd_byte = gain_ofs[0] ? man_gain[gain_ofs[2:1]][15:8] : man_gain[gain_ofs[2:1]][7:0];
    end else if (sub >= `OFS_RB_BASE && sub <= `OFS_RB_LAST) begin
      rd_byte = sub[0] ? ch_gain[sub[2:1]][15:8] : ch_gain[sub[2:1]][7:0];
    end
  end

  // ==========================================================================
  // Input routing and automatic clamp choice
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ch_src_sel <= '0;
      clamp_mid <= 4'h0;
      agc_active <= 1'b0;
    end else if (ce) begin
      ch_src_sel[0] <= route_reg[1:0];
      ch_src_sel[1] <= route_reg[3:2];
      ch_src_sel[2] <= route_reg[5:4];
      ch_src_sel[3] <= 2'b00; // Fourth channel has a single input
      for (int c = 0; c < 4; c++) begin
        clamp_mid[c] <= mid_clamp(route_reg[`ROUTE_KIND_LSB +: 2], c);
      end
      agc_active <= agc_en;
    end
  end

  // ==========================================================================
  // Front-end loops, one per channel, sharing one converter strobe
  for (genvar g = 0; g < 4; g++) begin : g_chan
    gain_channel #(
      .SAMPLE_W(SAMPLE_W)
    ) u_chan (
      .clk_sys(clk_sys),
      .reset(reset),
      .ce(ce),
      .agc_en(agc_en),
      .manual_gain(man_gain[g]),
      .ref_mask(ref_sel[`REF_FE_LSB +: 4]),
      .step_speed(step_speed),
      .step_delay(step_delay),
      .sample_en(adc_sample_en),
      .sample(adc_sample[g]),
      .line_end(line_end),
      .ref_high(fe_ref_high),
      .ref_low(fe_ref_low),
      .gain(ch_gain[g])
    );
  end

  // ==========================================================================
  // Back-end gain after luma/chroma split; lifts level lost to front-end cuts
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      be_gain <= `RST_BE_GAIN;
    end else if (ce) begin
      if (!agc_en) begin
        be_gain <= `RST_BE_GAIN;
      end else if (line_end) begin
        if (|(be_ref_high & be_mask) && be_gain != 8'h00) begin
          be_gain <= be_gain - 8'h01;
        end else if (be_mask != 4'h0 && &(be_ref_low | ~be_mask) && be_gain != `BE_MAX) begin
          be_gain <= be_gain + 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_addr_match;
    ce && state == ST_ADDR && scl_fall && bitcnt == 4'h8 && shreg[7:1] == DEV_ADDR;
  endsequence
  sequence s_lo_write;
    ce && reg_wr_en && !agc_en && reg_wr_addr == 8'h04 && !start_cond && !stop_cond;
  endsequence

  a_route_store: assert property (ce && reg_wr_en && reg_wr_addr == `OFS_ROUTE
    |=> route_reg == $past(reg_wr_data)) else $error("route not stored");
  a_clamp_auto: assert property ((ce && route_reg[7:6] == SRC_COMPONENT)[*2]
    |-> clamp_mid == 4'h5) else $error("component clamp wrong");
  a_coarse_write: assert property (ce && reg_wr_en && !agc_en && reg_wr_addr == 8'h05
    ##1 (ce && !agc_en) |=> ch_gain[1][15:12] == $past(reg_wr_data[7:4], 2))
    else $error("coarse code not applied");
  a_fine_indep: assert property (s_lo_write ##1 (ce && !agc_en)
    |=> ch_gain[1][15:8] == $past(man_gain[1][15:8], 2)) else $error("fine write moved coarse");
  a_manual_gain: assert property ((ce && !agc_en && !reg_wr_en)[*3]
    |-> ch_gain[1] == man_gain[1]) else $error("manual gain not applied");
  a_readback_live: assert property (ce && state == ST_ACK && scl_fall && ack_next == ST_READ
    && sub == `OFS_RB_BASE && !start_cond && !stop_cond |=> tx == $past(ch_gain[0][7:0]))
    else $error("readback not live gain");
  a_backend_raise: assert property (ce && agc_en && line_end && (be_ref_high & be_mask) == 4'h0
    && be_mask != 4'h0 && &(be_ref_low | ~be_mask) && be_gain != `BE_MAX
    |=> be_gain == $past(be_gain) + 8'h01) else $error("back-end gain did not rise");
  a_addr_ack: assert property ((s_addr_match and (!start_cond && !stop_cond))
    |=> sda_oe && state == ST_ACK) else $error("address not acknowledged");

endmodule

/* shared/vfgc_pkg.sv */
// Types shared by the gain control modules.
// Assumes compilation before every design module.
package vfgc_pkg;

  // ==========================================================================
  // Host port sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_SUB = 3'b010,
    ST_WRITE = 3'b011,
    ST_ACK = 3'b100,
    ST_READ = 3'b101,
    ST_RACK = 3'b110
  } i2c_state_e;

  // ==========================================================================
  // Kind of source wired onto the four channels
  typedef enum logic [1:0] {
    SRC_COMPOSITE = 2'b00,
    SRC_SVIDEO = 2'b01,
    SRC_COMPONENT = 2'b10,
    SRC_SCART = 2'b11
  } source_kind_e;

  typedef logic [15:0] gain_t;

endpackage

/* shared/vfgc_regs.svh */
// Register offsets, field positions, reset values and step sizes of the gain control block.
// Assumes inclusion by bare name from the design modules.
`ifndef VFGC_REGS_SVH
`define VFGC_REGS_SVH

// ==========================================================================
// Subaddresses
`define OFS_ROUTE 8'h00
`define OFS_AGC_CTRL 8'h01
`define OFS_GAIN_BASE 8'h02
`define OFS_GAIN_LAST 8'h09
`define OFS_RB_BASE 8'h10
`define OFS_RB_LAST 8'h17
`define OFS_BE_GAIN 8'h18
`define OFS_REF_SEL 8'h74
`define OFS_STEP_SPEED 8'h78
`define OFS_STEP_DELAY 8'h79

// ==========================================================================
// Field positions
`define AGC_EN_BIT 0
`define ROUTE_KIND_LSB 6
`define REF_FE_LSB 0
`define REF_BE_LSB 4
`define COARSE_LSB 12

// ==========================================================================
// Reset values
`define RST_ROUTE 8'h00
`define RST_AGC_CTRL 8'h01
`define RST_GAIN 16'h8000
`define RST_REF_SEL 8'h8f
`define RST_STEP_SPEED 8'h04
`define RST_STEP_DELAY 8'h10
`define RST_BE_GAIN 8'h80

// ==========================================================================
// Gain steps
`define AGC_STEP 16'h0010
`define AGC_MAX 16'hffff
`define BE_MAX 8'hff

`endif

/* test/host_model.sv */
// Host-side model of the two-wire register port: an open-drain master.
// Assumes the bench resolves SCL and SDA from every party's enable, with pull-ups.
module host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary value
) (
  // Clock
  input wire logic clk_sys,
  // Wire levels
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Bus phases
  // Idle: both lines released high
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Four cycles a phase so each level spans several samples
  task automatic qtr();
    repeat (4) @(negedge clk_sys);
  endtask

  // One bit cell; the answer is taken late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    qtr();
    scl = 1'b1;
    qtr();
    r = sda;
    scl = 1'b0;
  endtask

  // Start, also usable as a repeated start from a low clock
  task automatic start();
    sda_rel = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_rel = 1'b0;
    qtr();
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_rel = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_rel = 1'b1;
    qtr();
  endtask

  // Eight data bits then the acknowledge cell; m = 1 releases it
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
                      output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, r);
  endtask

  // ==========================================================================
  // Register transactions; ok is high when every byte that the host sent was acknowledged
  task automatic probe(input logic [6:0] a, output logic ok);
    logic [7:0] q;
    logic n0;
    start();
    xfer({a, 1'b0}, 1'b1, q, n0);
    stop();
    ok = !n0;
  endtask

  task automatic reg_write(input logic [7:0] sub, input logic [7:0] val, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, n0);
    xfer(sub, 1'b1, q, n1);
    xfer(val, 1'b1, q, n2);
    stop();
    ok = !(n0 | n1 | n2);
  endtask

  // Single-byte read ended by a not-acknowledge
  task automatic reg_read(input logic [7:0] sub, output logic [7:0] val, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, n0);
    xfer(sub, 1'b1, q, n1);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, q, n2);
    xfer(8'hff, 1'b1, val, n3);
    stop();
    ok = !(n0 | n1 | n2);
  endtask
endmodule

/* test/tb.sv */
// Self-checking bench of the video front-end gain control block.
// Assumes the host model file is compiled first; ce drops only for one frozen line.
module tb import vfgc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, reset, scl, sda_rel, scl_out, scl_oe, sda_out, sda_oe;
  logic ce, adc_sample_en, line_end, agc_active;
  logic [3:0][10:0] adc_sample;
  logic [3:0] fe_ref_high, fe_ref_low, be_ref_high, be_ref_low, clamp_mid;
  logic [3:0][1:0] ch_src_sel;
  gain_t [3:0] ch_gain;
  logic [7:0] be_gain;
  wire logic scl_w, sda_w;
  int err_count = 0;
  int n_tests = 0;

  // Open-drain resolution with pull-ups
  assign scl_w = scl & ~(scl_oe & ~scl_out);
  assign sda_w = sda_rel & ~(sda_oe & ~sda_out);

  video_frontend_gain_control u_video_frontend_gain_control (
    .clk_sys(clk_sys), .reset(reset), .ce(ce),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .adc_sample_en(adc_sample_en), .adc_sample(adc_sample), .line_end(line_end),
    .fe_ref_high(fe_ref_high), .fe_ref_low(fe_ref_low),
    .be_ref_high(be_ref_high), .be_ref_low(be_ref_low),
    .ch_src_sel(ch_src_sel), .clamp_mid(clamp_mid), .ch_gain(ch_gain),
    .be_gain(be_gain), .agc_active(agc_active));

  host_model u_host_model (.clk_sys(clk_sys), .scl(scl), .sda_rel(sda_rel), .sda(sda_w));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s: got %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] sub, input logic [7:0] val);
    logic ok;
    u_host_model.reg_write(sub, val, ok);
    check(ok, 1'b1, "write ack");
  endtask

  task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    u_host_model.reg_read(sub, v, ok);
    check({ok, v}, {1'b1, exp}, "read");
  endtask

  // One line: reference flags sampled with the end-of-line strobe
  task automatic line(input logic [3:0] fh, input logic [3:0] fl, input logic [3:0] bh,
                      input logic [3:0] bl);
    @(negedge clk_sys);
    {fe_ref_high, fe_ref_low, be_ref_high, be_ref_low} = {fh, fl, bh, bl};
    line_end = 1'b1;
    @(negedge clk_sys);
    line_end = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values();
    for (int c = 0; c < 4; c++) check(ch_gain[c], 16'h8000, "reset gain");
    check({agc_active, be_gain, clamp_mid, ch_src_sel}, {1'b1, 8'h80, 12'h000}, "reset");
    check({scl_oe, scl_out, sda_out, sda_oe}, 4'h0, "idle pins");
    rd(8'h00, 8'h00);
    rd(8'h74, 8'h8f);
    rd(8'h78, 8'h04);
    rd(8'h79, 8'h10);
  endtask

  // Cut, hold for the delay, then rise every second line
  task automatic t_agc_steps();
    logic [15:0] g [7] = '{16'h7ff0, 16'h7ff0, 16'h7ff0, 16'h7ff0, 16'h8000, 16'h8000,
                           16'h8010};
    wr(8'h79, 8'h02);
    wr(8'h78, 8'h01);
    for (int i = 0; i < 7; i++) begin
      if (i == 0) line(4'h1, 4'h0, 4'h8, 4'h0);
      else line(4'h0, 4'hf, 4'h0, 4'h8);
      for (int c = 0; c < 4; c++) check(ch_gain[c], g[i], "agc step");
      check(be_gain, 8'h7f + 8'(i), "back-end step");
    end
    // Clipping peak on channel 0 only
    @(negedge clk_sys);
    adc_sample[0] = 11'h7ff;
    adc_sample_en = 1'b1;
    @(negedge clk_sys);
    adc_sample_en = 1'b0;
    adc_sample[0] = 11'h100;
    line(4'h0, 4'hf, 4'h0, 4'h8);
    check(ch_gain[0], 16'h8000, "clip cut");
    check(ch_gain[1], 16'h8010, "no clip");
    check(be_gain, 8'h86, "back-end");
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h80);
  endtask

  // Unmasked flags must be ignored by both loops
  task automatic t_ref_masks();
    logic [15:0] g0 [3] = '{16'h8000, 16'h8000, 16'h8010};
    wr(8'h79, 8'h00);
    wr(8'h78, 8'h00);
    wr(8'h74, 8'h21);
    for (int i = 0; i < 3; i++) begin
      line(4'he, 4'h1, 4'hd, 4'h2);
      check(ch_gain[0], g0[i], "mask ch0");
      check(ch_gain[1], 16'h8020 + 16'(i) * 16'h0010, "mask ch1");
      check(be_gain, 8'h87 + 8'(i), "mask back-end");
    end
    // Frozen line: clock enable low must hold the channel 1 and back-end loops
    ce = 1'b0;
    line(4'h0, 4'h1, 4'h0, 4'h2);
    ce = 1'b1;
    check({be_gain, ch_gain[1]}, {8'h89, 16'h8040}, "ce freeze");
    // Empty front-end mask: flags alone never move the front-end gain
    wr(8'h74, 8'h20);
    line(4'hf, 4'h0, 4'h0, 4'h2);
    check(ch_gain[1], 16'h8040, "empty mask");
    check(be_gain, 8'h8a, "back-end only");
    rd(8'h18, 8'h8a);
  endtask

  task automatic t_manual();
    wr(8'h01, 8'h00);
    check({agc_active, be_gain, ch_gain[0]}, {1'b0, 8'h80, 16'h8000}, "agc off");
    wr(8'h04, 8'h34);
    wr(8'h05, 8'hf2);
    wr(8'h07, 8'h0a);
    line(4'hf, 4'h0, 4'hf, 4'h0);
    check(ch_gain[1], 16'hf234, "manual ch1");
    check(ch_gain[2], 16'h0a00, "manual ch2");
    rd(8'h12, 8'h34);
    rd(8'h13, 8'hf2);
  endtask

  // Every source kind; mid clamp only where the kind needs it
  task automatic t_routing();
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, {2'(k), 6'b000110});
      check({ch_src_sel[3], ch_src_sel[2], ch_src_sel[1], ch_src_sel[0]}, 8'h06, "route");
      check(clamp_mid, (k == 1 || k == 2) ? 4'b0101 : 4'b0000, "clamp");
      rd(8'h00, {2'(k), 6'b000110});
    end
  endtask

  task automatic t_refusals();
    logic ok;
    u_host_model.probe(7'h2b, ok);
    check(ok, 1'b0, "foreign address");
    rd(8'h20, 8'h00);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    adc_sample_en = 1'b0;
    line_end = 1'b0;
    adc_sample = {4{11'h100}};
    {fe_ref_high, fe_ref_low, be_ref_high, be_ref_low} = 16'h0000;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    t_reset_values();
    t_agc_steps();
    t_ref_masks();
    t_manual();
    t_routing();
    t_refusals();
    complete_run();
  end
endmodule
